// *** hdl/ea_consts.vh ***
// Constants of the nonvolatile access controller: register offsets, command codes,
// field positions, array geometry and timing.
// Included by every design file of the block; holds definitions only.
`ifndef EA_CONSTS_VH
`define EA_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus.
`define EA_REG_CMD        8'h00
`define EA_REG_STATUS     8'h04
`define EA_REG_CONFIG     8'h08
`define EA_REG_DATA       8'h0c

// Command register fields.
`define EA_CMD_CODE_LSB   0
`define EA_CMD_ARG_LSB    8
`define EA_CMD_DIR_BIT    24

// Status register bit positions.
`define EA_ST_BUSY_BIT    0
`define EA_ST_NACK_BIT    1
`define EA_ST_RDACT_BIT   2
`define EA_ST_WRACT_BIT   3
`define EA_ST_UNLOCK_BIT  4
`define EA_ST_REM_LSB     16

// Command codes.
`define EA_OP_RESTORE_DEF 8'h12
`define EA_OP_RD_COUNT    8'hd2
`define EA_OP_OFFSET      8'hd3
`define EA_OP_PAGE_ERASE  8'hd4
`define EA_OP_PASSWORD    8'hd5
`define EA_OP_AUX_READ    8'hf1
`define EA_OP_PAGE_BASE   4'hb

// Array geometry.
`define EA_PAGES          16
`define EA_PAGE_BYTES     512
`define EA_AUX_BYTES      128
`define EA_MAIN_XFER_MAX  9'h100
`define EA_AUX_XFER_MAX   9'h080
`define EA_FIRST_USER_PG  4'h4
`define EA_FIRST_OPEN_PG  4'h2

// Reset and factory values.
`define EA_PASSWORD_DEF   8'hff
`define EA_ERASED_BYTE    8'hff
`define EA_BAD_READ_BYTE  8'hff
`define EA_RESP_OKAY      2'b00
`define EA_RESP_SLVERR    2'b10

// Timing.
`define EA_CLK_FREQ_MHZ   10
`define EA_ERASE_TIME_US  35000

`endif

// *** hdl/ea_axil_slave.v ***
// AXI4-Lite slave front end of the nonvolatile access controller.
// Assumes one clock, synchronous active-high reset, and a core that decodes the
// address combinationally and answers a read in the same cycle it is strobed.
`include "ea_consts.vh"

module ea_axil_slave (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        wr_en,
  output reg  [7:0]  wr_addr_q,
  output reg  [31:0] wr_data_q,
  output reg  [3:0]  wr_strb_q,
  input  wire        wr_err,
  output wire        rd_en,
  output wire [7:0]  rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_err
);

  reg aw_have_q;
  reg w_have_q;

  // A write is issued once both address and data are held and no response waits.
  assign wr_en   = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign rd_en   = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always @(posedge ref_clk) begin
    if (rst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EA_RESP_OKAY;
      wr_addr_q     <= 8'h00;
      wr_data_q     <= 32'h0000_0000;
      wr_strb_q     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_q    <= s_axi_wdata;
        wr_strb_q    <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `EA_RESP_SLVERR : `EA_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `EA_RESP_OKAY;
    end else if (rd_en) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? `EA_RESP_SLVERR : `EA_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// *** hdl/ea_nvm_ctrl.v ***
// Nonvolatile access controller: main array of 16 pages, auxiliary fault array,
// page erase, counted reads and writes from a set offset, and password locking.
// Assumes an AXI4-Lite master on ref_clk and first-fault requests from core logic
// on the same clock.
//
// Summary of operation
// [RULE1] Auxiliary array holds 128 bytes as one page, apart from the main array.
// [RULE2] Main array is 16 pages of 512 bytes, numbered from zero.
// [RULE3] Erasing the auxiliary array sets every bit of its bytes to one.
// [RULE4] Auxiliary array is erased only internally, right before storing fault data.
// [RULE5] Page erase takes a page number; only pages 4-15, only while unlocked.
// [RULE6] Host waits at least 35 ms after a page erase before another command.
// [RULE7] Erase is whole pages; programming can only clear bits until next erase.
// [RULE8] Auxiliary read returns the programmed count from the programmed offset.
// [RULE9] Host programs the read count before reading either array.
// [RULE10] A programmable offset selects the first byte read or written.
// [RULE11] Auxiliary block read gives at most 128 bytes; first two hold fault data.
// [RULE12] Pages 0 and 1 read only while unlocked; else data is meaningless.
// [RULE13] Sixteen page commands read pages; pages 2-15 readable while locked.
// [RULE14] One main-array block read returns at most 256 bytes.
// [RULE15] One main-array block write accepts at most 256 bytes.
// [RULE16] No host path writes the auxiliary array.
// [RULE17] Writes aimed at pages 0 or 1 are refused and change nothing.
// [RULE18] Host should keep pages 2-3 untouched and use pages 4-15.
// [RULE19] Writes to pages 4-15 act only while unlocked, from the programmed offset.
// [RULE20] Power-up is locked; only reads of pages 2-15 allowed while locked. The code also accepts auxiliary reads while locked.
// [RULE21] Two consecutive correct password writes unlock; status bit 4 shows it.
// [RULE22] A wrong password write locks and clears the unlocked flag.
// [RULE23] Factory-default restore resets the password to all ones.
// [RULE24] Correct password then a new value with the same command changes it.
// [RULE25] Read count and offset persist until rewritten or reset.
// [RULE26] Any other command in between restarts the two-write unlock count.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "ea_consts.vh"

module ea_nvm_ctrl #(
  parameter ERASE_CYCLES = `EA_ERASE_TIME_US * `EA_CLK_FREQ_MHZ
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        fault_store,
  input  wire [15:0] fault_aux_array,
  output reg         unlocked_q,
  output reg         busy_q
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_ERASE = 2'd1;
  localparam [1:0] ST_AUX   = 2'd2;

  localparam [1:0] MD_NONE  = 2'd0;
  localparam [1:0] MD_MRD   = 2'd1;
  localparam [1:0] MD_ARD   = 2'd2;
  localparam [1:0] MD_MWR   = 2'd3;

  localparam [19:0] ERASE_LAST = ERASE_CYCLES[19:0] - 20'h00001;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus front end.

  wire        wr_en;
  wire [7:0]  wr_addr_q;
  wire [31:0] wr_data_q;
  wire [3:0]  wr_strb_q;
  wire        rd_en;
  wire [7:0]  rd_addr;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         wr_err;

  ea_axil_slave u_bus (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr_q     (wr_addr_q),
    .wr_data_q     (wr_data_q),
    .wr_strb_q     (wr_strb_q),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Arrays and control state.

  reg [7:0]  main_mem [0:`EA_PAGES*`EA_PAGE_BYTES-1]; // RULE2
  reg [7:0]  aux_mem  [0:`EA_AUX_BYTES-1];            // RULE1

  reg [1:0]  state_q;
  reg [19:0] cnt_q;
  reg [3:0]  erase_pg_q;
  reg        fault_pend_q;
  reg [15:0] fault_buf_q;

  reg [8:0]  rd_count_q;
  reg [8:0]  offset_q;
  reg [1:0]  mode_q;
  reg [3:0]  page_q;
  reg [8:0]  ptr_q;
  reg [8:0]  rem_q;
  reg        hide_q;
  reg        nack_q;
  reg [7:0]  password_q;
  reg        pw_ok_q;

  wire        cmd_wr  = wr_en && (wr_addr_q == `EA_REG_CMD) && wr_strb_q[0];
  wire        data_wr = wr_en && (wr_addr_q == `EA_REG_DATA) && wr_strb_q[0];
  wire        data_rd = rd_en && (rd_addr == `EA_REG_DATA);
  wire [7:0]  op      = wr_data_q[`EA_CMD_CODE_LSB +: 8];
  wire [8:0]  arg     = wr_data_q[`EA_CMD_ARG_LSB +: 9];
  wire        dir_rd  = wr_data_q[`EA_CMD_DIR_BIT];
  wire        idle    = (state_q == ST_IDLE);
  wire        rd_more = ((mode_q == MD_MRD) || (mode_q == MD_ARD)) && (rem_q != 9'h000);
  wire [12:0] main_ix = {page_q, ptr_q};
  wire [7:0]  pw_arg  = arg[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode.

  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (rd_addr)
      `EA_REG_STATUS: begin
        rd_data[`EA_ST_BUSY_BIT]        = busy_q;
        rd_data[`EA_ST_NACK_BIT]        = nack_q;
        rd_data[`EA_ST_RDACT_BIT]       = rd_more;
        rd_data[`EA_ST_WRACT_BIT]       = (mode_q == MD_MWR);
        rd_data[`EA_ST_UNLOCK_BIT]      = unlocked_q;                    // RULE21
        rd_data[`EA_ST_REM_LSB +: 9]    = rem_q;
      end
      `EA_REG_CONFIG: begin
        rd_data[8:0]   = rd_count_q;
        rd_data[24:16] = offset_q;
      end
      `EA_REG_DATA: begin
        if (!rd_more || hide_q) begin
          rd_data[7:0] = `EA_BAD_READ_BYTE;                                // RULE12
        end else if (mode_q == MD_ARD) begin
          rd_data[7:0] = aux_mem[ptr_q[6:0]];                              // RULE8
        end else begin
          rd_data[7:0] = main_mem[main_ix];                                // RULE13
        end
      end
      `EA_REG_CMD: rd_data = 32'h0000_0000;
      default: rd_err = 1'b1;
    endcase
  end

  always @* begin
    case (wr_addr_q)
      `EA_REG_CMD, `EA_REG_STATUS, `EA_REG_CONFIG, `EA_REG_DATA: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array write port; programming only clears bits.

  reg        main_we;
  reg [12:0] main_wa;
  reg [7:0]  main_wd;
  reg        aux_we;
  reg [6:0]  aux_wa;
  reg [7:0]  aux_wd;

  always @* begin
    main_we = 1'b0;
    main_wa = main_ix;
    main_wd = main_mem[main_ix] & wr_data_q[7:0];                          // RULE7
    aux_we  = 1'b0;
    aux_wa  = cnt_q[6:0];
    aux_wd  = `EA_ERASED_BYTE;
    if (state_q == ST_ERASE && cnt_q < `EA_PAGE_BYTES) begin
      main_we = 1'b1;
      main_wa = {erase_pg_q, cnt_q[8:0]};
      main_wd = `EA_ERASED_BYTE;                                           // RULE7
    end else if (data_wr && mode_q == MD_MWR && rem_q != 9'h000) begin
      main_we = 1'b1;                                                      // RULE15
    end
    if (state_q == ST_AUX) begin
      if (cnt_q < `EA_AUX_BYTES) begin
        aux_we = 1'b1;                                                     // RULE3
      end else if (cnt_q < `EA_AUX_BYTES + 2) begin
        aux_we = 1'b1;
        aux_wa = {6'h00, cnt_q[0]};
        aux_wd = cnt_q[0] ? fault_buf_q[15:8] : fault_buf_q[7:0];          // RULE11
      end
    end
  end

  always @(posedge ref_clk) begin
    if (main_we) begin
      main_mem[main_wa] <= main_wd;
    end
    if (aux_we) begin
      aux_mem[aux_wa] <= aux_wd;                                           // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Erase and first-fault store sequencer.

  always @(posedge ref_clk) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      busy_q       <= 1'b0;
      cnt_q        <= 20'h00000;
      fault_pend_q <= 1'b0;
      fault_buf_q  <= 16'h0000;
    end else begin
      if (fault_store) begin
        fault_pend_q <= 1'b1;
        fault_buf_q  <= fault_aux_array;
      end
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 20'h00000;
          if (cmd_wr && op == `EA_OP_PAGE_ERASE && unlocked_q &&
              arg >= {5'h00, `EA_FIRST_USER_PG} && arg < `EA_PAGES) begin  // RULE5
            state_q <= ST_ERASE;
            busy_q  <= 1'b1;
          end else if (fault_pend_q) begin
            state_q      <= ST_AUX;                                        // RULE4
            busy_q       <= 1'b1;
            fault_pend_q <= fault_store;
          end
        end
        ST_ERASE: begin
          cnt_q <= cnt_q + 20'h00001;
          if (cnt_q >= ERASE_LAST) begin                                   // RULE6
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        ST_AUX: begin
          cnt_q <= cnt_q + 20'h00001;
          if (cnt_q == `EA_AUX_BYTES + 1) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode, transfer sessions and password lock.

  always @(posedge ref_clk) begin
    if (rst) begin
      rd_count_q <= 9'h000;
      offset_q   <= 9'h000;
      mode_q     <= MD_NONE;
      page_q     <= 4'h0;
      ptr_q      <= 9'h000;
      rem_q      <= 9'h000;
      hide_q     <= 1'b0;
      nack_q     <= 1'b0;
      erase_pg_q <= 4'h0;
      password_q <= `EA_PASSWORD_DEF;
      pw_ok_q    <= 1'b0;
      unlocked_q <= 1'b0;                                                  // RULE20
    end else if (cmd_wr) begin
      nack_q  <= 1'b0;
      mode_q  <= MD_NONE;
      pw_ok_q <= 1'b0;                                                     // RULE26
      if (!idle) begin
        nack_q <= 1'b1;
      end else if (op[7:4] == `EA_OP_PAGE_BASE) begin
        page_q <= op[3:0];
        ptr_q  <= offset_q;                                                // RULE10
        if (dir_rd) begin
          mode_q <= MD_MRD;
          rem_q  <= (rd_count_q > `EA_MAIN_XFER_MAX) ? `EA_MAIN_XFER_MAX : rd_count_q; // RULE14
          hide_q <= (op[3:0] < `EA_FIRST_OPEN_PG) && !unlocked_q;          // RULE12
        end else if (op[3:0] < `EA_FIRST_OPEN_PG || !unlocked_q) begin
          nack_q <= 1'b1;                                                  // RULE17
          rem_q  <= 9'h000;
        end else begin
          mode_q <= MD_MWR;                                                // RULE19
          rem_q  <= `EA_MAIN_XFER_MAX;
          hide_q <= 1'b0;
        end
      end else begin
        case (op)
          `EA_OP_RD_COUNT: rd_count_q <= arg;                              // RULE25
          `EA_OP_OFFSET:   offset_q   <= arg;                              // RULE25
          `EA_OP_PAGE_ERASE: begin
            erase_pg_q <= arg[3:0];
            if (!unlocked_q || arg < {5'h00, `EA_FIRST_USER_PG} || arg >= `EA_PAGES) begin
              nack_q <= 1'b1;                                              // RULE5
            end
          end
          `EA_OP_AUX_READ: begin
            if (dir_rd) begin
              mode_q <= MD_ARD;
              ptr_q  <= {2'b00, offset_q[6:0]};                            // RULE8
              rem_q  <= (rd_count_q > `EA_AUX_XFER_MAX) ? `EA_AUX_XFER_MAX : rd_count_q; // RULE11
              hide_q <= 1'b0;
            end else begin
              nack_q <= 1'b1;                                              // RULE16
            end
          end
          `EA_OP_PASSWORD: begin
            if (pw_ok_q) begin
              if (pw_arg == password_q) begin
                unlocked_q <= 1'b1;                                        // RULE21
              end else begin
                password_q <= pw_arg;                                      // RULE24
              end
            end else if (pw_arg == password_q) begin
              pw_ok_q <= 1'b1;
            end else begin
              unlocked_q <= 1'b0;                                          // RULE22
            end
          end
          `EA_OP_RESTORE_DEF: password_q <= `EA_PASSWORD_DEF;              // RULE23
          default: nack_q <= 1'b1;
        endcase
      end
    end else if (data_wr) begin
      if (mode_q == MD_MWR && rem_q != 9'h000) begin
        ptr_q  <= ptr_q + 9'h001;
        rem_q  <= rem_q - 9'h001;
        nack_q <= 1'b0;
      end else begin
        nack_q <= 1'b1;                                                    // RULE15
      end
    end else if (data_rd && rd_more) begin
      rem_q <= rem_q - 9'h001;
      if (mode_q == MD_ARD) begin
        ptr_q <= {2'b00, ptr_q[6:0] + 7'h01};
      end else begin
        ptr_q <= ptr_q + 9'h001;
      end
    end
  end

endmodule

// *** verification/ea_chk.sv ***
// Checker for the nonvolatile access controller, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
module ea_chk (
  input logic        ref_clk,
  input logic        rst,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        fault_store,
  input logic        unlocked_q,
  input logic        busy_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_aw_w;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  AST_WR_ANSWER: assert property (s_aw_w |=> s_resp) else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while answering");
  AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  AST_LOCK_RESET: assert property ($past(rst) |-> !unlocked_q) else $error("unlocked after reset");
  AST_UNLOCK_CAUSE: assert property ($rose(unlocked_q) |-> $rose(s_axi_bvalid)) else $error("unlock without write");
  AST_LOCK_CAUSE: assert property ($fell(unlocked_q) |-> $rose(s_axi_bvalid)) else $error("lock without write");
  AST_AUX_STORE: assert property (fault_store && !busy_q |-> ##2 busy_q) else $error("fault store not started");
endmodule

// *** verification/ea_host.sv ***
// AXI4-Lite host model for the nonvolatile access controller.
// Assumes the bench calls wr and rd one at a time.
module ea_host (
  input  logic        ref_clk,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_b;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Released addresses and write data are inverted so that stale values are never mistaken for live ones.
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    @(posedge ref_clk);
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge ref_clk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
        s_axi_awaddr <= ~a;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 0;
        s_axi_wdata <= ~d;
      end
    end while (!(ad && wd));
    do @(posedge ref_clk); while (!s_axi_bvalid);
    last_b = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_araddr <= ~a;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
endmodule

// *** verification/test_eeprom_access_controller.sv ***
// Self-checking bench of the nonvolatile access controller.
// Assumes a 10 MHz clock and a shortened erase time.
module test_eeprom_access_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, fault_store = 0;
  logic [15:0] fault_aux_array = '0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, unlocked_q, busy_q;
  int miscompares = 0, checked = 0, seed = 84, i, pa;
  int mem [int];
  logic [7:0] b;
  logic [31:0] d;
  logic [1:0] r;
  ea_nvm_ctrl #(.ERASE_CYCLES(600)) DUT (.*);
  ea_host h (.*);
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cmd(input logic [7:0] op, input logic [8:0] arg, input logic dir);
    h.wr(8'h00, {7'h00, dir, 7'h00, arg, op});
  endtask
  task nk(input logic e);
    h.rd(8'h04, d, r);
    chk("nack", d[1], e);
    chk("bresp", h.last_b, 2'b00);
  endtask
  task ul(input logic e);
    h.rd(8'h04, d, r);
    chk("unlocked", d[4], e);
    chk("unlocked_q", unlocked_q, e);
  endtask
  task rdb(input logic [7:0] e);
    h.rd(8'h0c, d, r);
    chk("data", d[7:0], e);
  endtask
  task idle;
    for (int k = 0; k < 100; k++) begin
      h.rd(8'h04, d, r);
      if (d[0] === 1'b0) break;
      repeat (20) @(posedge ref_clk);
    end
    chk("busy", d[0], 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    ul(0);
    cmd(8'hd4, 9'h004, 0);
    nk(1);
    cmd(8'hd5, 9'h0ff, 0);
    cmd(8'hd3, 9'h000, 0);
    cmd(8'hd5, 9'h0ff, 0);
    ul(0);
    cmd(8'hd5, 9'h0ff, 0);
    ul(1);
    cmd(8'hd4, 9'h001, 0);
    nk(1);
    cmd(8'hd4, 9'h004, 0);
    idle;
    pa = 4 * 512 + 5;
    for (i = 0; i < 512; i++) mem[4 * 512 + i] = 8'hff;
    cmd(8'hd3, 9'h005, 0);
    cmd(8'hb4, 9'h000, 0);
    for (i = 0; i < 3; i++) begin
      b = $random(seed);
      mem[pa + i] &= b;
      h.wr(8'h0c, {24'h0, b});
    end
    nk(0);
    cmd(8'hb4, 9'h000, 0);
    b = $random(seed);
    mem[pa] &= b;
    h.wr(8'h0c, {24'h0, b});
    cmd(8'hd2, 9'h003, 0);
    cmd(8'hb4, 9'h000, 1);
    for (i = 0; i < 3; i++) rdb(mem[pa + i]);
    rdb(8'hff);
    cmd(8'hb4, 9'h000, 1);
    rdb(mem[pa]);
    h.rd(8'h08, d, r);
    chk("config", d, 32'h0005_0003);
    cmd(8'hb0, 9'h000, 0);
    nk(1);
    cmd(8'hd5, 9'h000, 0);
    ul(0);
    cmd(8'hb0, 9'h000, 1);
    rdb(8'hff);
    cmd(8'hb4, 9'h000, 1);
    rdb(mem[pa]);
    @(posedge ref_clk);
    fault_aux_array <= $random(seed);
    fault_store <= 1;
    @(posedge ref_clk);
    fault_store <= 0;
    idle;
    cmd(8'hd2, 9'h003, 0);
    cmd(8'hd3, 9'h000, 0);
    cmd(8'hf1, 9'h000, 1);
    rdb(fault_aux_array[7:0]);
    rdb(fault_aux_array[15:8]);
    rdb(8'hff);
    cmd(8'hd2, 9'h1ff, 0);
    cmd(8'hf1, 9'h000, 1);
    h.rd(8'h04, d, r);
    chk("aux_remain", d[24:16], 9'h080);
    cmd(8'hb4, 9'h000, 1);
    h.rd(8'h04, d, r);
    chk("page_remain", d[24:16], 9'h100);
    cmd(8'hf1, 9'h000, 0);
    nk(1);
    cmd(8'hd5, 9'h0ff, 0);
    cmd(8'hd5, 9'h0ff, 0);
    cmd(8'hd5, 9'h0ff, 0);
    cmd(8'hd5, 9'h05a, 0);
    cmd(8'hd5, 9'h000, 0);
    cmd(8'hd5, 9'h0ff, 0);
    cmd(8'hd5, 9'h0ff, 0);
    ul(0);
    cmd(8'hd5, 9'h05a, 0);
    cmd(8'hd5, 9'h05a, 0);
    ul(1);
    cmd(8'hd5, 9'h000, 0);
    cmd(8'h12, 9'h000, 0);
    cmd(8'hd5, 9'h0ff, 0);
    cmd(8'hd5, 9'h0ff, 0);
    ul(1);
    cmd(8'hb4, 9'h000, 0);
    for (i = 0; i < 256; i++) h.wr(8'h0c, 32'h0000_00ff);
    h.wr(8'h0c, 32'h0000_0000);
    nk(1);
    cmd(8'hd3, 9'h100, 0);
    cmd(8'hd2, 9'h001, 0);
    cmd(8'hb4, 9'h000, 1);
    rdb(8'hff);
    h.rd(8'h10, d, r);
    chk("rresp", r, 2'b10);
    wrap_up;
  end
endmodule
bind ea_nvm_ctrl ea_chk u_chk (.*);
